// File: shared/med_defines.svh
`ifndef MED_DEFINES_SVH
`define MED_DEFINES_SVH

// ----------------------------------------
// Code geometry
// ----------------------------------------
`define MED_BCH_W 7
`define MED_CHK_W 16
`define MED_GF_POLY 4'h3
`define MED_RS_INV_EXP 7
`define MED_RS_A_EXP 5

// ----------------------------------------
// Strap codes, last beat numbers and full byte mask
// ----------------------------------------
`define MED_PW_8 2'h0
`define MED_PW_32 2'h2
`define MED_BEAT_LAST_EDAC 3'h4
`define MED_BEAT_LAST_RAW 3'h3
`define MED_BE_FULL 4'hF

`endif

// File: shared/med_pkg.sv
`include "med_defines.svh"
`default_nettype none

package med_pkg;

    typedef enum logic [2:0] {
        MED_IDLE  = 3'b000,
        MED_ISSUE = 3'b001,
        MED_WAIT  = 3'b010,
        MED_CHECK = 3'b011,
        MED_RESP  = 3'b100
    } med_state_t;

    typedef enum logic [1:0] {
        MED_PROM  = 2'b00,
        MED_SRAM  = 2'b01,
        MED_SDRAM = 2'b10
    } med_area_t;

    typedef enum logic [1:0] {
        MED_CLEAN  = 2'b00,
        MED_CORR   = 2'b01,
        MED_UNCORR = 2'b10
    } med_stat_t;

    typedef logic [3:0] med_nib_t;

    // GF(16) multiply, field polynomial x^4 + x + 1
    function automatic med_nib_t med_gf_mul(input med_nib_t a, input med_nib_t b);
        med_nib_t p;
        med_nib_t aa;
        p = 4'h0;
        aa = a;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                p = p ^ aa;
            end
            aa = aa[3] ? ({aa[2:0], 1'b0} ^ `MED_GF_POLY) : {aa[2:0], 1'b0};
        end
        return p;
    endfunction : med_gf_mul

    function automatic med_nib_t med_gf_apow(input int k);
        med_nib_t v;
        v = 4'h1;
        for (int i = 0; i < 15; i++) begin
            if (i < k) begin
                v = med_gf_mul(v, 4'h2);
            end
        end
        return v;
    endfunction : med_gf_apow

endpackage : med_pkg

`default_nettype wire

// File: shared/med_rs_if.sv
`default_nettype none

interface med_rs_if;
    med_pkg::med_nib_t [3:0] enc_dat;
    med_pkg::med_nib_t [1:0] enc_chk;
    med_pkg::med_nib_t [5:0] dec_sym;
    med_pkg::med_nib_t [3:0] dec_fix;
    logic dec_corr;
    logic dec_bad;

    modport codec (input enc_dat, input dec_sym,
                   output enc_chk, output dec_fix, output dec_corr, output dec_bad);
    modport user (output enc_dat, output dec_sym,
                  input enc_chk, input dec_fix, input dec_corr, input dec_bad);
endinterface : med_rs_if

`default_nettype wire

// File: src/med_rs_cw.sv
`include "med_defines.svh"
`default_nettype none

module med_rs_cw (
    med_rs_if.codec rs
);

    med_pkg::med_nib_t sum_a;
    med_pkg::med_nib_t sum_b;
    med_pkg::med_nib_t p4;
    med_pkg::med_nib_t s0;
    med_pkg::med_nib_t s1;
    logic hit;

    // ----------------------------------------
    // Encoder: symbols 0..3 data, 4..5 check
    // ----------------------------------------
    always_comb begin
        sum_a = 4'h0;
        sum_b = 4'h0;
        for (int i = 0; i < 4; i++) begin
            sum_a = sum_a ^ rs.enc_dat[i];
            sum_b = sum_b ^ med_pkg::med_gf_mul(rs.enc_dat[i], med_pkg::med_gf_apow(i));
        end
        p4 = med_pkg::med_gf_mul(
            sum_b ^ med_pkg::med_gf_mul(sum_a, med_pkg::med_gf_apow(`MED_RS_A_EXP)),
            med_pkg::med_gf_apow(`MED_RS_INV_EXP));
        rs.enc_chk[0] = p4;
        rs.enc_chk[1] = sum_a ^ p4;
    end

    // ----------------------------------------
    // Decoder: one bad symbol anywhere
    // ----------------------------------------
    always_comb begin
        s0 = 4'h0;
        s1 = 4'h0;
        hit = 1'b0;
        for (int i = 0; i < 6; i++) begin
            s0 = s0 ^ rs.dec_sym[i];
            s1 = s1 ^ med_pkg::med_gf_mul(rs.dec_sym[i], med_pkg::med_gf_apow(i));
        end
        for (int i = 0; i < 4; i++) begin
            rs.dec_fix[i] = rs.dec_sym[i];
        end
        for (int j = 0; j < 6; j++) begin
            if (s0 != 4'h0 && med_pkg::med_gf_mul(s0, med_pkg::med_gf_apow(j)) == s1) begin
                hit = 1'b1;
                if (j < 4) begin
                    rs.dec_fix[j] = rs.dec_sym[j] ^ s0;
                end
            end
        end
        rs.dec_corr = hit;
        rs.dec_bad = (s0 != 4'h0 || s1 != 4'h0) && !hit;
    end

endmodule : med_rs_cw

`default_nettype wire

// File: src/med_codec.sv
// Behaviour
// - PROM/SRAM words use SEC-DED BCH code
// - RS mode: 48 bits form two codewords
// - Codewords interleave nibble by nibble
// - Codeword: four data, two check nibbles
// - Correct one bad nibble per codeword
// - Adjacent nibble pair errors are corrected
// - Whole 8-bit device failure is tolerated in RS mode
// - Sub-word writes do read-modify-write when EDAC is on
// - EDAC works on 8-bit PROM too
// - Width strap sampled at reset: 00/10
// - PROM EDAC strap sampled at reset
`include "med_defines.svh"
`default_nettype none

module med_codec #(
    parameter int ADDR_W = 28
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] strap_prom_width,
    input wire logic strap_prom_edac,
    input wire logic cfg_sdram_rs,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_area,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [3:0] req_byte_en,
    input wire logic [31:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    output logic [1:0] rsp_status,
    output logic rsp_error,
    output logic mem_req_valid,
    output logic mem_write,
    output logic [1:0] mem_area,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [2:0] mem_beat,
    output logic [3:0] mem_byte_en,
    output logic [31:0] mem_wdata,
    output logic [`MED_CHK_W-1:0] memory_check_bits_out,
    output logic mem_data_oe,
    input wire logic mem_done,
    input wire logic [31:0] mem_rdata,
    input wire logic [`MED_CHK_W-1:0] memory_check_bits_in
);

    // ----------------------------------------
    // BCH helpers
    // ----------------------------------------
    function automatic logic [`MED_BCH_W-1:0] bch_col(input int idx);
        logic [`MED_BCH_W-1:0] col;
        int cnt;
        col = 7'h00;
        cnt = 0;
        for (int v = 0; v < 128; v++) begin
            if ($countones(7'(v)) == 3) begin
                if (cnt == idx) begin
                    col = 7'(v);
                end
                cnt++;
            end
        end
        return col;
    endfunction : bch_col

    function automatic logic [`MED_BCH_W-1:0] bch_enc(input logic [31:0] d);
        logic [`MED_BCH_W-1:0] p;
        p = 7'h00;
        for (int i = 0; i < 32; i++) begin
            if (d[i]) begin
                p = p ^ bch_col(i);
            end
        end
        return p;
    endfunction : bch_enc

    function automatic logic edac_on(input logic [1:0] area, input logic prom_edac);
        return (area != med_pkg::MED_PROM) || prom_edac;
    endfunction : edac_on

    // ----------------------------------------
    // State
    // ----------------------------------------
    med_pkg::med_state_t state_reg, state_next;
    logic op_wr_reg, op_wr_next;
    logic rmw_reg, rmw_next;
    logic [1:0] area_reg, area_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [3:0] be_reg, be_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [31:0] word_reg, word_next;
    logic [`MED_CHK_W-1:0] chkr_reg, chkr_next;
    logic [2:0] beat_reg, beat_next;
    logic ready_reg, ready_next;
    logic rv_reg, rv_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rstat_reg, rstat_next;
    logic rerr_reg, rerr_next;
    logic mv_reg, mv_next;
    logic mw_reg, mw_next;
    logic [2:0] mbeat_reg, mbeat_next;
    logic [3:0] mbe_reg, mbe_next;
    logic [31:0] mwd_reg, mwd_next;
    logic [`MED_CHK_W-1:0] mchk_reg, mchk_next;
    logic oe_reg, oe_next;
    logic prom_w8_reg, prom_w8_next;
    logic prom_edac_reg, prom_edac_next;
    logic sdram_rs_reg, sdram_rs_next;

    // ----------------------------------------
    // Straps captured while reset is held
    // ----------------------------------------
    always_comb begin
        prom_w8_next = prom_w8_reg;
        prom_edac_next = prom_edac_reg;
        sdram_rs_next = sdram_rs_reg;
        if (sys_rst) begin
            prom_w8_next = (strap_prom_width != `MED_PW_32);
            prom_edac_next = strap_prom_edac;
            sdram_rs_next = cfg_sdram_rs;
        end
    end

    always_ff @(posedge core_clk) begin
        prom_w8_reg <= prom_w8_next;
        prom_edac_reg <= prom_edac_next;
        sdram_rs_reg <= sdram_rs_next;
    end

    // ----------------------------------------
    // Mode decode for the current access
    // ----------------------------------------
    logic use_edac;
    logic use_rs;
    logic narrow;
    logic [2:0] last_beat;

    assign use_edac = edac_on(area_reg, prom_edac_reg);
    assign use_rs = (area_reg == med_pkg::MED_SDRAM) && sdram_rs_reg;
    assign narrow = (area_reg == med_pkg::MED_PROM) && prom_w8_reg;
    assign last_beat = !narrow ? 3'h0 : (use_edac ? `MED_BEAT_LAST_EDAC : `MED_BEAT_LAST_RAW);

    // ----------------------------------------
    // Reed-Solomon codewords
    // ----------------------------------------
    logic [31:0] rs_fix_data;
    logic [`MED_CHK_W-1:0] rs_chk;
    logic [1:0] rs_corr;
    logic [1:0] rs_bad;

    for (genvar c = 0; c < 2; c++) begin : g_cw
        med_rs_if rs_bus ();
        med_rs_cw u_cw (
            .rs(rs_bus.codec)
        );
        for (genvar i = 0; i < 4; i++) begin : g_dat
            // Even nibbles to codeword 0, odd to codeword 1
            assign rs_bus.enc_dat[i] = wdata_reg[4*(2*i+c) +: 4];
            assign rs_bus.dec_sym[i] = word_reg[4*(2*i+c) +: 4];
            assign rs_fix_data[4*(2*i+c) +: 4] = rs_bus.dec_fix[i];
        end
        for (genvar j = 0; j < 2; j++) begin : g_chk
            assign rs_bus.dec_sym[4+j] = chkr_reg[4*(2*j+c) +: 4];
            assign rs_chk[4*(2*j+c) +: 4] = rs_bus.enc_chk[j];
        end
        assign rs_corr[c] = rs_bus.dec_corr;
        assign rs_bad[c] = rs_bus.dec_bad;
    end

    // ----------------------------------------
    // Decode and re-encode
    // ----------------------------------------
    logic [`MED_BCH_W-1:0] syn;
    logic [31:0] bch_data;
    logic bch_hit;
    logic [31:0] dec_data;
    logic [1:0] dec_stat;
    logic [`MED_CHK_W-1:0] enc_chk;
    logic [31:0] merged;

    always_comb begin
        syn = bch_enc(word_reg) ^ chkr_reg[`MED_BCH_W-1:0];
        bch_data = word_reg;
        bch_hit = ($countones(syn) == 1);
        for (int i = 0; i < 32; i++) begin
            if (syn == bch_col(i)) begin
                bch_data[i] = ~word_reg[i];
                bch_hit = 1'b1;
            end
        end
        if (!use_edac) begin
            dec_data = word_reg;
            dec_stat = med_pkg::MED_CLEAN;
        end else if (use_rs) begin
            dec_data = rs_fix_data;
            dec_stat = (|rs_bad) ? med_pkg::MED_UNCORR
                     : (|rs_corr) ? med_pkg::MED_CORR : med_pkg::MED_CLEAN;
        end else begin
            dec_data = bch_data;
            dec_stat = (syn == 7'h00) ? med_pkg::MED_CLEAN
                     : (bch_hit && ^syn) ? med_pkg::MED_CORR : med_pkg::MED_UNCORR;
        end
        enc_chk = use_rs ? rs_chk : {9'h000, bch_enc(wdata_reg)};
        for (int b = 0; b < 4; b++) begin
            merged[8*b +: 8] = be_reg[b] ? wdata_reg[8*b +: 8] : dec_data[8*b +: 8];
        end
    end

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        op_wr_next = op_wr_reg;
        rmw_next = rmw_reg;
        area_next = area_reg;
        addr_next = addr_reg;
        be_next = be_reg;
        wdata_next = wdata_reg;
        word_next = word_reg;
        chkr_next = chkr_reg;
        beat_next = beat_reg;
        ready_next = ready_reg;
        rv_next = 1'b0;
        rdata_next = rdata_reg;
        rstat_next = rstat_reg;
        rerr_next = rerr_reg;
        mv_next = 1'b0;
        mw_next = mw_reg;
        mbeat_next = mbeat_reg;
        mbe_next = mbe_reg;
        mwd_next = mwd_reg;
        mchk_next = mchk_reg;
        oe_next = oe_reg;
        unique case (state_reg)
            med_pkg::MED_IDLE: begin
                if (req_valid && ready_reg) begin
                    area_next = req_area;
                    addr_next = req_addr;
                    be_next = req_byte_en;
                    wdata_next = req_wdata;
                    beat_next = 3'h0;
                    rmw_next = req_write;
                    op_wr_next = req_write && (req_byte_en == `MED_BE_FULL
                                 || !edac_on(req_area, prom_edac_reg));
                    ready_next = 1'b0;
                    state_next = med_pkg::MED_ISSUE;
                end
            end
            med_pkg::MED_ISSUE: begin
                mv_next = 1'b1;
                mw_next = op_wr_reg;
                oe_next = op_wr_reg;
                mbeat_next = beat_reg;
                mchk_next = op_wr_reg ? enc_chk : 16'h0000;
                if (narrow) begin
                    mbe_next = (use_edac || beat_reg[2] || !op_wr_reg) ? 4'h1
                             : {3'h0, be_reg[~beat_reg[1:0]]};
                    mwd_next = beat_reg[2] ? {24'h000000, enc_chk[7:0]}
                             : {24'h000000, wdata_reg[{~beat_reg[1:0], 3'b000} +: 8]};
                end else begin
                    mbe_next = (op_wr_reg && !use_edac) ? be_reg : `MED_BE_FULL;
                    mwd_next = wdata_reg;
                end
                state_next = med_pkg::MED_WAIT;
            end
            med_pkg::MED_WAIT: begin
                if (mem_done) begin
                    oe_next = 1'b0;
                    if (!op_wr_reg) begin
                        if (!narrow) begin
                            word_next = mem_rdata;
                            chkr_next = memory_check_bits_in;
                        end else if (beat_reg[2]) begin
                            chkr_next = {8'h00, mem_rdata[7:0]};
                        end else begin
                            word_next[{~beat_reg[1:0], 3'b000} +: 8] = mem_rdata[7:0];
                        end
                    end
                    if (beat_reg != last_beat) begin
                        beat_next = beat_reg + 3'h1;
                        state_next = med_pkg::MED_ISSUE;
                    end else if (op_wr_reg) begin
                        rv_next = 1'b1;
                        rdata_next = 32'h00000000;
                        rstat_next = med_pkg::MED_CLEAN;
                        rerr_next = 1'b0;
                        state_next = med_pkg::MED_RESP;
                    end else begin
                        state_next = med_pkg::MED_CHECK;
                    end
                end
            end
            med_pkg::MED_CHECK: begin
                if (rmw_reg && dec_stat != med_pkg::MED_UNCORR) begin
                    wdata_next = merged;
                    op_wr_next = 1'b1;
                    beat_next = 3'h0;
                    state_next = med_pkg::MED_ISSUE;
                end else begin
                    rv_next = 1'b1;
                    rdata_next = rmw_reg ? 32'h00000000 : dec_data;
                    rstat_next = dec_stat;
                    rerr_next = (dec_stat == med_pkg::MED_UNCORR);
                    state_next = med_pkg::MED_RESP;
                end
            end
            med_pkg::MED_RESP: begin
                ready_next = 1'b1;
                state_next = med_pkg::MED_IDLE;
            end
            default: begin
                ready_next = 1'b1;
                state_next = med_pkg::MED_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= med_pkg::MED_IDLE;
            op_wr_reg <= 1'b0;
            rmw_reg <= 1'b0;
            area_reg <= 2'h0;
            addr_reg <= '0;
            be_reg <= 4'h0;
            wdata_reg <= 32'h00000000;
            word_reg <= 32'h00000000;
            chkr_reg <= 16'h0000;
            beat_reg <= 3'h0;
            ready_reg <= 1'b1;
            rv_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rstat_reg <= 2'h0;
            rerr_reg <= 1'b0;
            mv_reg <= 1'b0;
            mw_reg <= 1'b0;
            mbeat_reg <= 3'h0;
            mbe_reg <= 4'h0;
            mwd_reg <= 32'h00000000;
            mchk_reg <= 16'h0000;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_wr_reg <= op_wr_next;
            rmw_reg <= rmw_next;
            area_reg <= area_next;
            addr_reg <= addr_next;
            be_reg <= be_next;
            wdata_reg <= wdata_next;
            word_reg <= word_next;
            chkr_reg <= chkr_next;
            beat_reg <= beat_next;
            ready_reg <= ready_next;
            rv_reg <= rv_next;
            rdata_reg <= rdata_next;
            rstat_reg <= rstat_next;
            rerr_reg <= rerr_next;
            mv_reg <= mv_next;
            mw_reg <= mw_next;
            mbeat_reg <= mbeat_next;
            mbe_reg <= mbe_next;
            mwd_reg <= mwd_next;
            mchk_reg <= mchk_next;
            oe_reg <= oe_next;
        end
    end

    assign req_ready = ready_reg;
    assign rsp_valid = rv_reg;
    assign rsp_rdata = rdata_reg;
    assign rsp_status = rstat_reg;
    assign rsp_error = rerr_reg;
    assign mem_req_valid = mv_reg;
    assign mem_write = mw_reg;
    assign mem_area = area_reg;
    assign mem_addr = addr_reg;
    assign mem_beat = mbeat_reg;
    assign mem_byte_en = mbe_reg;
    assign mem_wdata = mwd_reg;
    assign memory_check_bits_out = mchk_reg;
    assign mem_data_oe = oe_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking med_dc @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic chk_rd;
    assign chk_rd = state_reg == med_pkg::MED_CHECK && !rmw_reg && use_edac;

    sequence s_subword_take;
        state_reg == med_pkg::MED_IDLE && req_valid && ready_reg && req_write
        && req_byte_en != `MED_BE_FULL && edac_on(req_area, prom_edac_reg);
    endsequence
    sequence s_read_issue;
        mem_req_valid && !mem_write && mem_byte_en != 4'h0;
    endsequence

    rmw_read_a: assert property (s_subword_take |-> ##2 s_read_issue)
        else $error("sub-word write did not start with a read");
    rmw_write_a: assert property (state_reg == med_pkg::MED_CHECK && rmw_reg
        && dec_stat != med_pkg::MED_UNCORR |-> ##2 (mem_req_valid && mem_write
        && mem_data_oe))
        else $error("merged word not written back");
    bch_fix_a: assert property (chk_rd && !use_rs && ^syn && bch_hit
        |=> rsp_valid && rsp_status == med_pkg::MED_CORR && !rsp_error)
        else $error("single bit error not corrected");
    bch_double_a: assert property (chk_rd && !use_rs && syn != 7'h00 && !(^syn)
        |=> rsp_valid && rsp_error)
        else $error("double bit error not flagged");
    rs_fix_a: assert property (chk_rd && use_rs && (|rs_corr) && !(|rs_bad)
        |=> rsp_status == med_pkg::MED_CORR && rsp_rdata == $past(rs_fix_data))
        else $error("nibble error not corrected");
    rs_pair_a: assert property (chk_rd && use_rs && rs_corr == 2'h3 && rs_bad == 2'h0
        |=> rsp_valid && !rsp_error)
        else $error("adjacent nibble pair not corrected");
    err_resp_a: assert property (rsp_valid |-> rsp_error == (rsp_status == med_pkg::MED_UNCORR)
        ##1 !rsp_valid)
        else $error("error response does not match status");
    strap_width_a: assert property ($past(sys_rst) |->
        prom_w8_reg == ($past(strap_prom_width) != `MED_PW_32))
        else $error("width strap not captured at reset");
    strap_edac_a: assert property ($past(sys_rst) |->
        prom_edac_reg == $past(strap_prom_edac) && sdram_rs_reg == $past(cfg_sdram_rs))
        else $error("edac strap not captured at reset");
    cfg_hold_a: assert property ($stable(sdram_rs_reg) && $stable(prom_w8_reg))
        else $error("configuration changed outside reset");
    narrow_beat_a: assert property (mem_req_valid && narrow |-> mem_beat <= `MED_BEAT_LAST_EDAC
        && mem_byte_en[3:1] == 3'h0 && (mem_byte_en[0] || mem_write && !use_edac))
        else $error("narrow beat out of range");

endmodule : med_codec

`default_nettype wire

// File: verification/med_mem_model.sv
`default_nettype none

module med_mem_model (
    input wire logic core_clk,
    input wire logic mem_req_valid,
    input wire logic mem_write,
    input wire logic [1:0] mem_area,
    input wire logic [27:0] mem_addr,
    input wire logic [2:0] mem_beat,
    input wire logic [3:0] mem_byte_en,
    input wire logic [31:0] mem_wdata,
    input wire logic [15:0] memory_check_bits_out,
    input wire logic [47:0] flip,
    output logic mem_done,
    output logic [31:0] mem_rdata,
    output logic [15:0] memory_check_bits_in,
    output int beats
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [47:0] mem [int];
    logic [47:0] w;
    int key;
    int dly;
    logic pend = 1'b0;
    initial begin
        {mem_done, memory_check_bits_in, mem_rdata} = 49'h0;
        beats = 0;
    end
    always @(posedge core_clk) begin
        mem_done <= 1'b0;
        // Idle bus toggles rather than hold the last word
        {memory_check_bits_in, mem_rdata} <= ~{memory_check_bits_in, mem_rdata};
        if (mem_req_valid) begin
            key = {mem_area, mem_addr[23:0], mem_beat};
            w = mem.exists(key) ? mem[key] : 48'h0;
            if (mem_write) begin
                for (int i = 0; i < 4; i++) begin
                    if (mem_byte_en[i]) w[8*i+:8] = mem_wdata[8*i+:8];
                end
                w[47:32] = memory_check_bits_out;
                mem[key] = w;
            end else if (mem_beat == 3'h0) begin
                // Upset injected on the first beat only
                w = w ^ flip;
            end
            dly = $urandom_range(3, 0);
            pend = 1'b1;
            beats = beats + 1;
        end else if (pend && dly > 0) begin
            dly = dly - 1;
        end else if (pend) begin
            pend = 1'b0;
            mem_done <= 1'b1;
            {memory_check_bits_in, mem_rdata} <= w;
        end
    end
endmodule : med_mem_model

`default_nettype wire

// File: verification/memory_edac_codec_tb.sv
`default_nettype none

module memory_edac_codec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] strap_prom_width = 2'h2;
    logic strap_prom_edac = 1'b1;
    logic cfg_sdram_rs = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_area = 2'h0;
    logic [27:0] req_addr = 28'h10;
    logic [3:0] req_byte_en = 4'hF;
    logic [31:0] req_wdata = 32'h0;
    logic req_ready, rsp_valid, rsp_error, mem_req_valid, mem_write, mem_data_oe, mem_done;
    logic [31:0] rsp_rdata, mem_wdata, mem_rdata, wd, wn;
    logic [1:0] rsp_status, mem_area;
    logic [27:0] mem_addr;
    logic [2:0] mem_beat;
    logic [3:0] mem_byte_en;
    logic [15:0] memory_check_bits_out, memory_check_bits_in;
    logic [47:0] flip = 48'h0;
    int beats, b0, i, j, error_cnt = 0, cmp_count = 0;

    med_codec dut (.*);
    med_mem_model mem_model (.*);

    always @(negedge core_clk) begin
        if (mem_req_valid) begin
            check("mem bus", {18'h0, req_area, req_addr}, {18'h0, mem_area, mem_addr});
            check("data oe", {47'h0, mem_write}, {47'h0, mem_data_oe});
        end
    end

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic xfer(input logic wr, input logic [1:0] ar, input logic [3:0] be,
                        input logic [31:0] d);
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        b0 = beats;
        {req_valid, req_write, req_area, req_byte_en, req_wdata} = {1'b1, wr, ar, be, d};
        @(negedge core_clk);
        req_valid = 1'b0;
        repeat (200) if (rsp_valid !== 1'b1) @(negedge core_clk);
        check("response", 48'h1, {47'h0, rsp_valid});
    endtask : xfer

    task automatic rd_chk(input logic [1:0] ar, input logic [31:0] d, input logic [1:0] st);
        xfer(1'b0, ar, 4'hF, 32'h0);
        if (st != 2'h2) check("read data", {16'h0, d}, {16'h0, rsp_rdata});
        check("status", {45'h0, st, st == 2'h2}, {45'h0, rsp_status, rsp_error});
    endtask : rd_chk

    task automatic do_reset(input logic [1:0] w, input logic e, input logic rs);
        @(negedge core_clk);
        {sys_rst, strap_prom_width, strap_prom_edac, cfg_sdram_rs} = {1'b1, w, e, rs};
        repeat (12) @(negedge core_clk);
        sys_rst = 1'b0;
    endtask : do_reset

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] be);
        for (int k = 0; k < 4; k++) begin
            if (be[k]) o[8*k+:8] = n[8*k+:8];
        end
        return o;
    endfunction : merge

    function automatic logic [47:0] nib(input int k);
        return 48'($urandom_range(15, 1)) << (4 * k);
    endfunction : nib

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        final_report();
    end

    initial begin
        void'($urandom(32'h5386d404));
        do_reset(2'h2, 1'b1, 1'b0);
        repeat (6) begin
            wd = $urandom();
            req_addr = 28'($urandom());
            flip = 48'h0;
            xfer(1'b1, 2'h1, 4'hF, wd);
            rd_chk(2'h1, wd, 2'h0);
            i = $urandom_range(38, 0);
            j = (i + 1 + $urandom_range(37, 0)) % 39;
            flip = 48'h1 << i;
            rd_chk(2'h1, wd, 2'h1);
            flip = flip | (48'h1 << j);
            rd_chk(2'h1, wd, 2'h2);
        end
        flip = 48'h0;
        wn = $urandom();
        xfer(1'b1, 2'h1, 4'h2, wn);
        check("rmw beats", 48'h2, 48'(beats - b0));
        wd = merge(wd, wn, 4'h2);
        rd_chk(2'h1, wd, 2'h0);
        flip = 48'h3;
        xfer(1'b1, 2'h1, 4'h1, $urandom());
        check("rmw error", 48'h1, {47'h0, rsp_error});
        flip = 48'h0;
        rd_chk(2'h1, wd, 2'h0);
        xfer(1'b1, 2'h2, 4'hF, wd);
        flip = 48'h30;
        rd_chk(2'h2, wd, 2'h2);
        do_reset(2'h2, 1'b1, 1'b1);
        for (int k = 0; k < 12; k++) begin
            wd = $urandom();
            flip = 48'h0;
            xfer(1'b1, 2'h2, 4'hF, wd);
            flip = nib(k);
            rd_chk(2'h2, wd, 2'h1);
            if (k < 11) flip = flip | nib(k + 1);
            rd_chk(2'h2, wd, 2'h1);
        end
        flip = 48'h0;
        xfer(1'b1, 2'h0, 4'hF, wd);
        check("wide beats", 48'h1, 48'(beats - b0));
        flip = 48'h80;
        rd_chk(2'h0, wd, 2'h1);
        do_reset(2'h0, 1'b1, 1'b0);
        flip = 48'h0;
        xfer(1'b1, 2'h0, 4'hF, wd);
        check("narrow beats", 48'h5, 48'(beats - b0));
        flip = 48'h1;
        rd_chk(2'h0, wd, 2'h1);
        do_reset(2'h0, 1'b0, 1'b0);
        rd_chk(2'h0, wd ^ 32'h01000000, 2'h0);
        check("raw beats", 48'h4, 48'(beats - b0));
        // Raw narrow sub-word write goes out with per-byte enables
        xfer(1'b1, 2'h0, 4'h4, wn);
        check("raw wr beats", 48'h4, 48'(beats - b0));
        rd_chk(2'h0, merge(wd ^ 32'h01000000, wn, 4'h4), 2'h0);
        final_report();
    end
endmodule : memory_edac_codec_tb

`default_nettype wire
